// File: rtl/irl_buf2.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none

module irl_buf2 #(
    parameter int W = 64
) (
    input  wire logic         mclk,      // clock
    input  wire logic         resetn,    // async reset, low
    input  wire logic         in_valid,  // word offered
    output logic              in_ready,  // room for a word
    input  wire logic [W-1:0] in_data,   // word in
    output logic              out_valid, // head word present
    input  wire logic         out_ready, // receiver takes head
    output logic      [W-1:0] out_data   // head word
);

    logic         head_vld_ff;
    logic         tail_vld_ff;
    logic [W-1:0] head_ff;
    logic [W-1:0] tail_ff;
    logic         pop;
    logic         push;

    // ready depends on a flop only, so the source sees no combinational path
    assign in_ready  = !tail_vld_ff;
    assign out_valid = head_vld_ff;
    assign out_data  = head_ff;
    assign pop       = head_vld_ff && out_ready;
    assign push      = in_valid && !tail_vld_ff;

    // head refills from the tail first so word order is kept
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            head_vld_ff <= 1'b0;
            tail_vld_ff <= 1'b0;
            head_ff     <= '0;
            tail_ff     <= '0;
        end else if (!head_vld_ff || pop) begin
            if (tail_vld_ff) begin
                head_ff     <= tail_ff;
                head_vld_ff <= 1'b1;
                tail_vld_ff <= 1'b0;
            end else begin
                head_ff     <= in_data;
                head_vld_ff <= push;
            end
        end else if (push) begin
            tail_ff     <= in_data;
            tail_vld_ff <= 1'b1;
        end
    end

endmodule // irl_buf2

`default_nettype wire

// File: rtl/irl_loader.sv
// id rom table loader and autoinitialisation engine
`timescale 1ns/10ps
`default_nettype none
`include "irl_regs.svh"

module irl_loader (
    input  wire logic            mclk,          // 10 MHz clock
    input  wire logic            resetn,        // async reset, low
    input  wire logic [11:0]     rb_addr,       // register byte address
    input  wire logic [31:0]     rb_wdata,      // register write data
    input  wire logic            rb_wr,         // write strobe
    input  wire logic            rb_rd,         // read strobe
    output logic      [31:0]     rb_rdata,      // read data, cycle after strobe
    output logic      [31:0]     rom_addr,      // rom word address
    output logic                 rom_rd,        // rom read pulse
    input  wire logic [31:0]     rom_data,      // rom data pins
    output logic                 rom_guard_pin, // high while comms boot reads rom
    output logic                 dst_valid,     // destination write offered
    input  wire logic            dst_ready,     // destination accepts
    output irl_pkg::irl_wr_t     dst_word       // destination address and data
);

    // ------------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------------
    irl_pkg::irl_state_t state_ff;
    irl_pkg::irl_width_t width_ff;
    irl_pkg::irl_wr_t    push_word;
    logic [31:0]         tbl_mem [0:255];
    logic                comms_ff;
    logic                skip_ff;
    logic                start;
    logic [31:0]         rom_meta_ff;
    logic [31:0]         rom_sync_ff;
    logic                fetch_on;
    logic [4:0]          spc_cnt_ff;
    logic [4:0]          beat_ff;
    logic [4:0]          beat_last;
    logic [31:0]         asm_ff;
    logic [31:0]         nxt_asm;
    logic                word_vld_ff;
    logic [31:0]         word_ff;
    logic [7:0]          widx_ff;
    logic [7:0]          total_ff;
    logic [7:0]          rptr_ff;
    logic [2:0]          setup_idx_ff;
    logic [31:0]         blk_len_ff;
    logic [31:0]         blk_addr_ff;
    logic                push_valid;
    logic                push_ready;
    logic                busy_ff;
    logic                done_ff;
    logic                err_size_ff;
    logic                err_term_ff;
    logic [31:0]         cur_word;
    logic                at_end;
    logic                ainit_bad;
    logic [31:0]         rd_val;

    // ------------------------------------------------------------------------
    // control register
    // ------------------------------------------------------------------------
    // start is honoured only when idle; a start mid-load would corrupt the table
    assign start = rb_wr && (rb_addr == `IRL_REG_CTRL) && rb_wdata[`IRL_CTL_START]
                   && (state_ff == irl_pkg::S_IDLE);

    // mode bits are frozen during a load
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            comms_ff <= 1'b0;
            skip_ff  <= 1'b0;
            width_ff <= irl_pkg::WID_WORD;
        end else if (rb_wr && (rb_addr == `IRL_REG_CTRL) && (state_ff == irl_pkg::S_IDLE)) begin
            comms_ff <= rb_wdata[`IRL_CTL_COMMS];
            skip_ff  <= rb_wdata[`IRL_CTL_SKIP];
            width_ff <= irl_pkg::irl_width_t'(rb_wdata[`IRL_CTL_WID_HI:`IRL_CTL_WID_LO]);
        end
    end

    // ------------------------------------------------------------------------
    // rom pin synchroniser
    // ------------------------------------------------------------------------
    // the rom drives its pins without our clock, so two flops before any use
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rom_meta_ff <= '0;
            rom_sync_ff <= '0;
        end else begin
            rom_meta_ff <= rom_data;
            rom_sync_ff <= rom_meta_ff;
        end
    end

    // ------------------------------------------------------------------------
    // word fetcher
    // ------------------------------------------------------------------------
    // within a load, reads stay sequential and at least the rom gap apart, for slow serial parts
    assign fetch_on = (state_ff == irl_pkg::S_READ);

    always_comb begin
        beat_last = 5'h00;
        nxt_asm   = rom_sync_ff;
        unique case (width_ff)
            irl_pkg::WID_NIBBLE: begin
                beat_last = 5'h07;
                nxt_asm   = {rom_sync_ff[3:0], asm_ff[31:4]};
            end
            irl_pkg::WID_SERIAL: begin
                beat_last = 5'h1f;
                nxt_asm   = {rom_sync_ff[0], asm_ff[31:1]};
            end
            default: begin
                beat_last = 5'h00;
                nxt_asm   = rom_sync_ff;
            end
        endcase
    end

    // spacing counter, read pulse and sample point share one time base
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            spc_cnt_ff  <= 5'h00;
            beat_ff     <= 5'h00;
            asm_ff      <= '0;
            word_ff     <= '0;
            word_vld_ff <= 1'b0;
            rom_rd      <= 1'b0;
            rom_addr    <= `IRL_ROM_BASE;
        end else if (!fetch_on) begin
            spc_cnt_ff  <= 5'h00;
            beat_ff     <= 5'h00;
            word_vld_ff <= 1'b0;
            rom_rd      <= 1'b0;
            if (start) begin
                rom_addr <= `IRL_ROM_BASE;
            end
        end else begin
            spc_cnt_ff  <= (spc_cnt_ff == `IRL_GAP_CYC - 5'h01) ? 5'h00 : spc_cnt_ff + 5'h01;
            rom_rd      <= (spc_cnt_ff == 5'h00);
            word_vld_ff <= 1'b0;
            if (spc_cnt_ff == `IRL_ROM_LAT_CYC + `IRL_SYNC_CYC) begin
                asm_ff   <= nxt_asm;
                rom_addr <= rom_addr + 32'h0000_0001;
                if (beat_ff == beat_last) begin
                    beat_ff     <= 5'h00;
                    word_ff     <= nxt_asm;
                    word_vld_ff <= 1'b1;
                end else begin
                    beat_ff <= beat_ff + 5'h01;
                end
            end
        end
    end

    // guard pin only in comms boot; the start write's own mode bit raises it a cycle early
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rom_guard_pin <= 1'b0;
        end else begin
            rom_guard_pin <= (start && rb_wdata[`IRL_CTL_COMMS]) ||
                             (comms_ff && fetch_on && !(word_vld_ff && at_end));
        end
    end

    // ------------------------------------------------------------------------
    // table memory
    // ------------------------------------------------------------------------
    // the whole table lands at the base of memory before anything is applied
    always_ff @(posedge mclk) begin
        if (word_vld_ff && fetch_on) begin
            tbl_mem[widx_ff] <= word_ff;
        end
    end

    assign cur_word  = tbl_mem[rptr_ff];
    assign at_end    = (widx_ff == total_ff - 8'h01) && (widx_ff > `IRL_IDX_AINIT);
    assign ainit_bad = (word_ff < `IRL_AINIT_MIN) || (word_ff > `IRL_AINIT_MAX);

    // ------------------------------------------------------------------------
    // setup word selection
    // ------------------------------------------------------------------------
    // timers first, bus control last: the rom is no longer needed by then
    always_comb begin
        push_word = '0;
        unique case (setup_idx_ff)
            3'h0: push_word = '{`IRL_DST_T0PER, tbl_mem[`IRL_IDX_T0PER]};
            3'h1: push_word = '{`IRL_DST_T0CTL, {16'h0000, tbl_mem[`IRL_IDX_TCTL][15:0]}};
            3'h2: push_word = '{`IRL_DST_T1PER, tbl_mem[`IRL_IDX_T1PER]};
            3'h3: push_word = '{`IRL_DST_T1CTL, {16'h0000, tbl_mem[`IRL_IDX_TCTL][31:16]}};
            3'h4: push_word = '{`IRL_DST_GBUS, tbl_mem[`IRL_IDX_GBUS]};
            3'h5: push_word = '{`IRL_DST_LBUS, tbl_mem[`IRL_IDX_LBUS]};
            default: push_word = '0;
        endcase
        if (state_ff == irl_pkg::S_BDATA) begin
            push_word = '{blk_addr_ff, cur_word};
        end
    end

    assign push_valid = (state_ff == irl_pkg::S_SETUP) ||
                        ((state_ff == irl_pkg::S_BDATA) && (rptr_ff < total_ff));

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    // any destination write waits for the full rom read, so a bus setup write
    // can never cut the loader off from the rom
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_ff     <= irl_pkg::S_IDLE;
            widx_ff      <= 8'h00;
            total_ff     <= `IRL_FIXED_WORDS;
            rptr_ff      <= 8'h00;
            setup_idx_ff <= 3'h0;
            blk_len_ff   <= '0;
            blk_addr_ff  <= '0;
        end else begin
            unique case (state_ff)
                irl_pkg::S_IDLE: begin
                    if (start) begin
                        state_ff <= irl_pkg::S_READ;
                        widx_ff  <= 8'h00;
                        total_ff <= `IRL_FIXED_WORDS;
                    end
                end
                irl_pkg::S_READ: begin
                    if (word_vld_ff) begin
                        widx_ff <= widx_ff + 8'h01;
                        if ((widx_ff == `IRL_IDX_AINIT) && ainit_bad) begin
                            state_ff <= irl_pkg::S_IDLE;
                        end else if (widx_ff == `IRL_IDX_AINIT) begin
                            total_ff <= `IRL_FIXED_WORDS + word_ff[7:0];
                        end else if (at_end) begin
                            state_ff     <= irl_pkg::S_SETUP;
                            setup_idx_ff <= 3'h0;
                        end
                    end
                end
                irl_pkg::S_SETUP: begin
                    if (push_ready) begin
                        setup_idx_ff <= setup_idx_ff + 3'h1;
                        if (setup_idx_ff == `IRL_SETUP_LAST) begin
                            rptr_ff  <= `IRL_FIXED_WORDS;
                            state_ff <= skip_ff ? irl_pkg::S_IDLE : irl_pkg::S_BSIZE;
                        end
                    end
                end
                irl_pkg::S_BSIZE: begin
                    if (rptr_ff >= total_ff) begin
                        state_ff <= irl_pkg::S_IDLE;
                    end else if (cur_word == 32'h0000_0000) begin
                        state_ff <= irl_pkg::S_IDLE;
                    end else begin
                        blk_len_ff <= cur_word;
                        rptr_ff    <= rptr_ff + 8'h01;
                        state_ff   <= irl_pkg::S_BADDR;
                    end
                end
                irl_pkg::S_BADDR: begin
                    if (rptr_ff >= total_ff) begin
                        state_ff <= irl_pkg::S_IDLE;
                    end else begin
                        blk_addr_ff <= cur_word;
                        rptr_ff     <= rptr_ff + 8'h01;
                        state_ff    <= irl_pkg::S_BDATA;
                    end
                end
                irl_pkg::S_BDATA: begin
                    if (rptr_ff >= total_ff) begin
                        state_ff <= irl_pkg::S_IDLE;
                    end else if (push_ready) begin
                        rptr_ff     <= rptr_ff + 8'h01;
                        blk_addr_ff <= blk_addr_ff + 32'h0000_0001;
                        blk_len_ff  <= blk_len_ff - 32'h0000_0001;
                        if (blk_len_ff == 32'h0000_0001) begin
                            state_ff <= irl_pkg::S_BSIZE;
                        end
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------------------
    // done and error flags clear on start and busy sets; an error or done event cannot coincide with start
    // since start needs the idle state, in which neither is raised
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            busy_ff     <= 1'b0;
            done_ff     <= 1'b0;
            err_size_ff <= 1'b0;
            err_term_ff <= 1'b0;
        end else begin
            busy_ff <= (state_ff != irl_pkg::S_IDLE) || start;
            if (start) begin
                done_ff     <= 1'b0;
                err_size_ff <= 1'b0;
                err_term_ff <= 1'b0;
            end
            if ((state_ff == irl_pkg::S_READ) && word_vld_ff && (widx_ff == `IRL_IDX_AINIT) && ainit_bad) begin
                err_size_ff <= 1'b1;
            end
            if ((state_ff != irl_pkg::S_READ) && (state_ff != irl_pkg::S_SETUP) &&
                (state_ff != irl_pkg::S_IDLE) && (rptr_ff >= total_ff)) begin
                err_term_ff <= 1'b1;
            end
            if ((state_ff == irl_pkg::S_SETUP) && push_ready && (setup_idx_ff == `IRL_SETUP_LAST) && skip_ff) begin
                done_ff <= 1'b1;
            end
            if ((state_ff == irl_pkg::S_BSIZE) && (rptr_ff < total_ff) && (cur_word == 32'h0000_0000)) begin
                done_ff <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------------------
    // upper window shows the loaded table word by word; unmapped reads give zero
    always_comb begin
        rd_val = 32'h0000_0000;
        if (rb_addr[11:10] == `IRL_WIN_SEL) begin
            rd_val = tbl_mem[rb_addr[9:2]];
        end else begin
            unique case (rb_addr)
                `IRL_REG_CTRL:  rd_val = {27'h0, skip_ff, width_ff, comms_ff, 1'b0};
                `IRL_REG_STAT:  rd_val = {28'h0, err_term_ff, err_size_ff, done_ff, busy_ff};
                `IRL_REG_ID0:   rd_val = tbl_mem[`IRL_IDX_ID0];
                `IRL_REG_ID1:   rd_val = tbl_mem[`IRL_IDX_ID1];
                `IRL_REG_LOAD:  rd_val = tbl_mem[`IRL_IDX_LOAD];
                `IRL_REG_AINIT: rd_val = tbl_mem[`IRL_IDX_AINIT];
                default:        rd_val = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rb_rdata <= 32'h0000_0000;
        end else if (rb_rd) begin
            rb_rdata <= rd_val;
        end else begin
            rb_rdata <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------------
    // destination write buffer
    // ------------------------------------------------------------------------
    // a stalled destination fills the buffer and then holds the sequence
    irl_buf2 #(
        .W ($bits(irl_pkg::irl_wr_t))
    ) u_buf (
        .mclk      (mclk),
        .resetn    (resetn),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (push_word),
        .out_valid (dst_valid),
        .out_ready (dst_ready),
        .out_data  (dst_word)
    );

endmodule // irl_loader

`default_nettype wire

// File: rtl/irl_pkg.sv
// types shared by the id rom loader files
package irl_pkg;

    // one destination write: address and data travel together
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
    } irl_wr_t;

    // rom data path width
    typedef enum logic [1:0] {
        WID_WORD,
        WID_NIBBLE,
        WID_SERIAL,
        WID_RSVD
    } irl_width_t;

    typedef enum logic [2:0] {
        S_IDLE,
        S_READ,
        S_SETUP,
        S_BSIZE,
        S_BADDR,
        S_BDATA
    } irl_state_t;

endpackage

// File: rtl/irl_regs.svh
// register offsets, table layout and timing constants of the id rom loader
// Notes on behaviour
// - records are size word, address, then data
// - zero block size ends autoinitialisation
// - copy all records first, then write destinations
// - guard pin high during comms-boot rom access
// - boot mode selects rom or comms load; here both modes read the rom, comms only raises the guard pin
// - write internal setup values after table load
// - then process further autoinitialisation blocks
// - read whole rom before any reconfiguration
`ifndef IRL_REGS_SVH
`define IRL_REGS_SVH

// ----------------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------------
`define IRL_REG_CTRL     12'h000
`define IRL_REG_STAT     12'h004
`define IRL_REG_ID0      12'h008
`define IRL_REG_ID1      12'h00c
`define IRL_REG_LOAD     12'h010
`define IRL_REG_AINIT    12'h014
`define IRL_WIN_SEL      2'h1
`define IRL_CTL_START    0
`define IRL_CTL_COMMS    1
`define IRL_CTL_WID_LO   2
`define IRL_CTL_WID_HI   3
`define IRL_CTL_SKIP     4
`define IRL_CTRL_RST     5'h00

// ----------------------------------------------------------------------------
// table layout, word indices
// ----------------------------------------------------------------------------
`define IRL_IDX_SIZE     8'h00
`define IRL_IDX_LOAD     8'h01
`define IRL_IDX_ID0      8'h02
`define IRL_IDX_ID1      8'h03
`define IRL_IDX_T0PER    8'h0e
`define IRL_IDX_T1PER    8'h0f
`define IRL_IDX_TCTL     8'h10
`define IRL_IDX_GBUS     8'h11
`define IRL_IDX_LBUS     8'h12
`define IRL_IDX_AINIT    8'h13
`define IRL_FIXED_WORDS  8'h14
`define IRL_AINIT_MIN    32'h0000_0001
`define IRL_AINIT_MAX    32'h0000_00de
`define IRL_SETUP_LAST   3'h5

// ----------------------------------------------------------------------------
// destinations of internal setup words and rom location
// ----------------------------------------------------------------------------
`define IRL_DST_T0PER    32'h0010_0028
`define IRL_DST_T0CTL    32'h0010_0020
`define IRL_DST_T1PER    32'h0010_0038
`define IRL_DST_T1CTL    32'h0010_0030
`define IRL_DST_GBUS     32'h0010_0000
`define IRL_DST_LBUS     32'h0010_0004
`define IRL_ROM_BASE     32'h7000_0000

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define IRL_CLK_NS       100
`define IRL_ROM_GAP_NS   2000
`define IRL_GAP_CYC      (5'((`IRL_ROM_GAP_NS + `IRL_CLK_NS - 1) / `IRL_CLK_NS))
`define IRL_ROM_LAT_CYC  5'h04
`define IRL_SYNC_CYC     5'h02

`endif

// File: test/irl_props.sv
// port assertions of the id rom loader
`timescale 1ns/10ps
`default_nettype none
`include "irl_regs.svh"

module irl_props (
    input wire logic             mclk,          // clock
    input wire logic             resetn,        // reset, low
    input wire logic             rb_rd,         // read strobe
    input wire logic [31:0]      rb_rdata,      // read data
    input wire logic [31:0]      rom_addr,      // rom address
    input wire logic             rom_rd,        // rom read
    input wire logic             rom_guard_pin, // guard level
    input wire logic             dst_valid,     // write offered
    input wire logic             dst_ready,     // write taken
    input wire irl_pkg::irl_wr_t dst_word       // write payload
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);

    property p_gap; rom_rd |=> !rom_rd [*8] ##1 !rom_rd [*8]; endproperty
    a_gap: assert property (p_gap) else $error("rom reads too close");
    property p_win; rom_rd |-> rom_addr[31:8] == 24'h700000; endproperty
    a_win: assert property (p_win) else $error("rom read outside rom");
    property p_seq; $changed(rom_addr) |-> rom_addr == $past(rom_addr) + 32'h1 || rom_addr == `IRL_ROM_BASE;
    endproperty
    a_seq: assert property (p_seq) else $error("rom address skipped");
    property p_step; rom_rd |=> $stable(rom_addr) [*3] ##[1:4] $changed(rom_addr); endproperty
    a_step: assert property (p_step) else $error("rom address not advanced");
    property p_lead; $rose(rom_guard_pin) |=> rom_rd; endproperty
    a_lead: assert property (p_lead) else $error("guard rose without read");
    property p_copy; rom_guard_pin |-> !dst_valid; endproperty
    a_copy: assert property (p_copy) else $error("write during rom copy");
    property p_hold; dst_valid && !dst_ready |=> dst_valid && $stable(dst_word); endproperty
    a_hold: assert property (p_hold) else $error("stalled write lost");
    property p_idle; !$past(rb_rd) |-> rb_rdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data outside slot");
endmodule // irl_props

bind irl_loader irl_props u_props (.mclk(mclk), .resetn(resetn), .rb_rd(rb_rd), .rb_rdata(rb_rdata),
    .rom_addr(rom_addr), .rom_rd(rom_rd), .rom_guard_pin(rom_guard_pin), .dst_valid(dst_valid),
    .dst_ready(dst_ready), .dst_word(dst_word));

`default_nettype wire

// File: test/irl_rom_model.sv
// behavioural id rom on the local strobe
`timescale 1ns/10ps
`default_nettype none

module irl_rom_model (
    input  wire logic [31:0] rom_addr, // word address
    input  wire logic        mclk,     // clock
    input  wire logic        rom_rd,   // read pulse
    output logic      [31:0] rom_data  // data pins
);
    logic [31:0] mem [0:255]; // table image, loaded by the bench
    logic [3:0]  age = 4'hf;  // cycles since the last read

    // data hold only a few cycles after a read; later the pins drift, shown inverted
    always_ff @(posedge mclk) begin
        age <= rom_rd ? 4'h0 : (age == 4'hf ? age : age + 4'h1);
    end
    assign rom_data = (age < 4'h8) ? mem[rom_addr[7:0]] : ~mem[rom_addr[7:0]];
endmodule // irl_rom_model

`default_nettype wire

// File: test/tb.sv
// self-checking bench of the id rom loader
`timescale 1ns/10ps
`default_nettype none
`include "irl_regs.svh"

module tb;
    logic             mclk, resetn, rb_wr, rb_rd, rom_rd, rom_guard_pin, dst_valid, dst_ready, exp_guard;
    logic [11:0]      rb_addr;
    logic [31:0]      rb_wdata, rb_rdata, rom_addr, rom_data, v;
    irl_pkg::irl_wr_t dst_word;
    irl_pkg::irl_wr_t exp_q[$];
    int               errors, checks, cyc, seed = 96;

    irl_loader dut (.mclk(mclk), .resetn(resetn), .rb_addr(rb_addr), .rb_wdata(rb_wdata), .rb_wr(rb_wr),
        .rb_rd(rb_rd), .rb_rdata(rb_rdata), .rom_addr(rom_addr), .rom_rd(rom_rd), .rom_data(rom_data),
        .rom_guard_pin(rom_guard_pin), .dst_valid(dst_valid), .dst_ready(dst_ready), .dst_word(dst_word));
    irl_rom_model rom (.rom_addr(rom_addr), .mclk(mclk), .rom_rd(rom_rd), .rom_data(rom_data));

    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %s exp %h got %h", name, exp, got);
        end
    endtask

    task automatic close_out;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic rd(input logic [11:0] a);
        rb_addr <= a;
        rb_rd <= 1'b1;
        @(posedge mclk);
        rb_rd <= 1'b0;
        #1 v = rb_rdata;
        @(posedge mclk);
    endtask

    // random table, one block of two words, then the zero terminator
    task automatic run(input logic [4:0] ctrl, input logic [31:0] n);
        logic [31:0] t [0:24];
        logic        good;
        int          i;
        good = n >= 32'h1 && n <= 32'hde;
        for (i = 0; i < 25; i++) t[i] = $random(seed);
        t[0] = 32'h0000_0014;
        t[1] = 32'h002f_f800;
        t[2][15:0] = 16'h1234; // arbitrary maker value
        t[3][31:24] = 8'h00;
        t[19] = n;
        t[20] = 32'h2;
        t[24] = 32'h0;
        for (i = 0; i < 200; i++) begin
            v = $random(seed);
            rom.mem[i] = ctrl[2] ? {v[31:4], t[i / 8][(i % 8) * 4 +: 4]} : t[i % 25];
        end
        if (good) begin
            exp_q.push_back({`IRL_DST_T0PER, t[14]});
            exp_q.push_back({`IRL_DST_T0CTL, 16'h0, t[16][15:0]});
            exp_q.push_back({`IRL_DST_T1PER, t[15]});
            exp_q.push_back({`IRL_DST_T1CTL, 16'h0, t[16][31:16]});
            exp_q.push_back({`IRL_DST_GBUS, t[17]});
            exp_q.push_back({`IRL_DST_LBUS, t[18]});
            if (!ctrl[4]) exp_q.push_back({t[21], t[22]});
            if (!ctrl[4]) exp_q.push_back({t[21] + 32'h1, t[23]});
        end
        exp_guard = ctrl[1];
        rb_addr <= `IRL_REG_CTRL;
        rb_wdata <= {27'h0, ctrl};
        rb_wr <= 1'b1;
        @(posedge mclk);
        rb_wr <= 1'b0;
        i = 0;
        do begin
            rd(`IRL_REG_STAT);
            i++;
        end while (v[0] !== 1'b0 && i < 3000);
        chk("busy", 64'h0, {63'h0, v[0]});
        for (i = 0; i < 100 && exp_q.size() > 0; i++) @(posedge mclk);
        chk("writes left", 64'h0, 64'(exp_q.size()));
        chk("size error", {63'h0, !good}, {63'h0, v[2]});
        if (good) chk("done", 64'h2, {62'h0, v[1:0]});
        rd(`IRL_REG_ID0);
        chk("id0", {32'h0, t[2]}, {32'h0, v});
        rd(`IRL_REG_AINIT);
        chk("init size", {32'h0, n}, {32'h0, v});
        $display("test ctrl %h size %0d over", ctrl, n);
    endtask

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // random stalls of the receiver, write checks, guard checks and the hang limit
    always @(posedge mclk) begin
        dst_ready <= ($random(seed) & 3) != 0;
        if (dst_valid === 1'b1 && dst_ready === 1'b1) begin
            if (exp_q.size() == 0) chk("extra write", 64'h0, dst_word);
            else chk("dst write", exp_q.pop_front(), dst_word);
        end
        if (rom_rd === 1'b1) chk("guard", {63'h0, exp_guard}, {63'h0, rom_guard_pin});
        cyc++;
        if (cyc > 20000) begin
            errors++;
            close_out();
        end
    end

    initial begin
        {resetn, rb_wr, rb_rd, exp_guard} = 4'h0;
        rb_addr = 12'h000;
        rb_wdata = 32'h0;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        run(5'h03, 32'h5);
        run(5'h07, 32'h5);
        run(5'h11, 32'h5);
        run(5'h03, 32'h0);
        run(5'h01, 32'hdf);
        rd(12'h018);
        chk("unmapped", 64'h0, {32'h0, v});
        close_out();
    end
endmodule // tb

`default_nettype wire
